/* rtc_pkg.sv */
// Register map, field layout and limits of the time-of-day counter block
package rtc_pkg;

    // ==================================================================
    // Register byte offsets on the peripheral bus
    localparam logic [7:0] OFF_SS = 8'h00;          // Seconds counter
    localparam logic [7:0] OFF_HH_MM = 8'h04;       // Hour and minute counters
    localparam logic [7:0] OFF_STATUS = 8'h08;      // Event flags, write one to clear
    localparam logic [7:0] OFF_ENABLE = 8'h0C;      // Interrupt enables
    localparam logic [7:0] OFF_COUNTDOWN = 8'h10;   // Minute countdown
    localparam logic [7:0] OFF_DAYS = 8'h14;        // Elapsed day counter
    localparam logic [7:0] OFF_ALARM_SS = 8'h18;    // Alarm seconds
    localparam logic [7:0] OFF_ALARM_HH_MM = 8'h1C; // Alarm hour and minute
    localparam logic [7:0] OFF_ALARM_DATE = 8'h20;  // Alarm day

    // ==================================================================
    // Field widths and positions
    localparam int SEC_W = 6;
    localparam int MIN_W = 6;
    localparam int HOUR_W = 5;
    localparam int DAY_W = 16;
    localparam int CNT_W = 6;
    localparam int MIN_LSB = 0;
    localparam int HOUR_LSB = 8;
    localparam int FLAG_W = 6;

    // Status and enable bit positions
    localparam int BIT_COUNTDOWN = 0;
    localparam int BIT_MINUTE = 1;
    localparam int BIT_ALARM = 2;
    localparam int BIT_MIDNIGHT = 3;
    localparam int BIT_SECOND = 4;
    localparam int BIT_HOURLY = 5;

    // ==================================================================
    // Counter limits
    localparam logic [SEC_W-1:0] SEC_LAST = 6'h3B;   // 59
    localparam logic [MIN_W-1:0] MIN_LAST = 6'h3B;   // 59
    localparam logic [HOUR_W-1:0] HOUR_LAST = 5'h17; // 23
    localparam logic [CNT_W-1:0] CNT_EXPIRED = 6'h3F; // Minus one in six bits

    // ==================================================================
    // Reset values of the software settings
    localparam logic [FLAG_W-1:0] ENABLE_RST = 6'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 6'h3F;

endpackage

/* rtc_day_counter.sv */
// Time-of-day counter with day count, alarm and minute countdown, APB slave
`timescale 1ns/1ps

// ==================================================================
// Behaviour notes
//
// Timing of the tick path:
//   The one-hertz tick is a pin and is not related to the bus clock.
//   Two flip-flops bring it into the bus domain, and a third keeps the
//   last synchronised level for the edge detect. The seconds counter and
//   the per-second flag therefore move three bus edges after the pin rises.
//   The tick must stay high and low for at least three bus cycles each,
//   or an edge can be lost in the synchroniser.
//
// Carry chain:
//   Every carry is worked out in the same cycle as the seconds step, so
//   all counters that roll over move together on one edge. There is no
//   ripple delay between seconds, minutes, hours and days.
//
// Software writes:
//   A write to a counter register wins over a tick in the same cycle.
//   That tick is then lost for that register only; the carry into the
//   next register still happens. Software that sets the time should
//   write from the smallest unit up to avoid a carry in between.
//
// Alarm:
//   The compare looks at the time one cycle after each tick, once the
//   chain has settled. A write to the time or the alarm registers alone
//   never fires the alarm, so setting the alarm to the present time does
//   not raise a spurious flag. The alarm stays armed after a hit.
//
// Countdown:
//   The countdown steps on minute ticks only, so its first step comes
//   anywhere up to a minute after the load. Once it reaches minus one it
//   holds there and flags at every minute tick until it is reloaded.
//
// Reset:
//   Time registers carry no reset so that time survives a system reset.
//   In simulation they read unknown until software writes them.

module rtc_day_counter (
    input wire logic pclk,              // Bus clock, 20 MHz
    input wire logic presetn,           // Asynchronous reset, active low
    input wire logic psel,              // APB select
    input wire logic penable,           // APB access phase
    input wire logic pwrite,            // APB direction, high for write
    input wire logic [7:0] paddr,       // APB byte address
    input wire logic [31:0] pwdata,     // APB write data
    input wire logic [3:0] pstrb,       // APB write byte strobes
    output logic [31:0] prdata,         // APB read data
    output logic pready,                // APB ready
    output logic pslverr,               // APB error for unmapped address
    input wire logic tick_1hz,          // Supplied one-hertz tick from a pin
    output logic irq                    // Interrupt request, active high
);

    // ==================================================================
    // Tick synchroniser and edge detect
    logic tick_meta_q;
    logic tick_sync_q;
    logic tick_last_q;
    logic sec_tick;

    // Tick arrives from outside the bus clock domain; two stages first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_meta_q <= 1'b0;
            tick_sync_q <= 1'b0;
            tick_last_q <= 1'b0;
        end else begin
            tick_meta_q <= tick_1hz;
            tick_sync_q <= tick_meta_q;
            tick_last_q <= tick_sync_q;
        end
    end

    // One cycle per rising tick edge, however long the tick stays high
    assign sec_tick = tick_sync_q & ~tick_last_q;

    // ==================================================================
    // Bus decode
    logic setup_ph;
    logic access_wr;
    logic addr_ok;
    logic wr_ss;
    logic wr_hh_mm;
    logic wr_status;
    logic wr_enable;
    logic wr_cnt;
    logic wr_days;
    logic wr_al_ss;
    logic wr_al_hh_mm;
    logic wr_al_date;

    assign setup_ph = psel & ~penable;
    assign access_wr = psel & penable & pready & pwrite & ~pslverr;

    // Address check used to flag unmapped accesses
    // Every mapped word is listed; any other address is refused
    always_comb begin
        unique case (paddr)
            rtc_pkg::OFF_SS,
            rtc_pkg::OFF_HH_MM,
            rtc_pkg::OFF_STATUS,
            rtc_pkg::OFF_ENABLE,
            rtc_pkg::OFF_COUNTDOWN,
            rtc_pkg::OFF_DAYS,
            rtc_pkg::OFF_ALARM_SS,
            rtc_pkg::OFF_ALARM_HH_MM,
            rtc_pkg::OFF_ALARM_DATE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Write strobes, valid only at the completing access edge
    assign wr_ss = access_wr && (paddr == rtc_pkg::OFF_SS);
    assign wr_hh_mm = access_wr && (paddr == rtc_pkg::OFF_HH_MM);
    assign wr_status = access_wr && (paddr == rtc_pkg::OFF_STATUS);
    assign wr_enable = access_wr && (paddr == rtc_pkg::OFF_ENABLE);
    assign wr_cnt = access_wr && (paddr == rtc_pkg::OFF_COUNTDOWN);
    assign wr_days = access_wr && (paddr == rtc_pkg::OFF_DAYS);
    assign wr_al_ss = access_wr && (paddr == rtc_pkg::OFF_ALARM_SS);
    assign wr_al_hh_mm = access_wr && (paddr == rtc_pkg::OFF_ALARM_HH_MM);
    assign wr_al_date = access_wr && (paddr == rtc_pkg::OFF_ALARM_DATE);

    // ==================================================================
    // Time-of-day counter chain
    logic [rtc_pkg::SEC_W-1:0] sec_q;
    logic [rtc_pkg::MIN_W-1:0] min_q;
    logic [rtc_pkg::HOUR_W-1:0] hour_q;
    logic [rtc_pkg::DAY_W-1:0] day_q;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic min_tick;
    logic hour_tick;
    logic day_tick;

    assign sec_wrap = (sec_q == rtc_pkg::SEC_LAST);
    assign min_wrap = (min_q == rtc_pkg::MIN_LAST);
    assign hour_wrap = (hour_q == rtc_pkg::HOUR_LAST);
    assign min_tick = sec_tick & sec_wrap;
    assign hour_tick = min_tick & min_wrap;
    assign day_tick = hour_tick & hour_wrap;

    // Counters carry no reset: time must survive a system reset.
    // A software write in the same cycle as a tick wins over the count.
    always_ff @(posedge pclk) begin
        if (wr_ss) begin
            sec_q <= pwdata[rtc_pkg::SEC_W-1:0];
        end else if (sec_tick) begin
            sec_q <= sec_wrap ? '0 : sec_q + 1'b1;
        end
    end

    // Hours and minutes share one register
    always_ff @(posedge pclk) begin
        if (wr_hh_mm) begin
            min_q <= pwdata[rtc_pkg::MIN_LSB +: rtc_pkg::MIN_W];
            hour_q <= pwdata[rtc_pkg::HOUR_LSB +: rtc_pkg::HOUR_W];
        end else begin
            if (min_tick) begin
                min_q <= min_wrap ? '0 : min_q + 1'b1;
            end
            if (hour_tick) begin
                hour_q <= hour_wrap ? '0 : hour_q + 1'b1;
            end
        end
    end

    // Day counter wraps naturally after 65536 days
    always_ff @(posedge pclk) begin
        if (wr_days) begin
            day_q <= pwdata[rtc_pkg::DAY_W-1:0];
        end else if (day_tick) begin
            day_q <= day_q + 1'b1;
        end
    end

    // ==================================================================
    // Alarm settings and compare
    logic [rtc_pkg::SEC_W-1:0] al_sec_q;
    logic [rtc_pkg::MIN_W-1:0] al_min_q;
    logic [rtc_pkg::HOUR_W-1:0] al_hour_q;
    logic [rtc_pkg::DAY_W-1:0] al_day_q;
    logic time_moved_q;
    logic alarm_hit;

    // Alarm registers mirror the three time registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            al_sec_q <= '0;
            al_min_q <= '0;
            al_hour_q <= '0;
            al_day_q <= '0;
        end else begin
            if (wr_al_ss) begin
                al_sec_q <= pwdata[rtc_pkg::SEC_W-1:0];
            end
            if (wr_al_hh_mm) begin
                al_min_q <= pwdata[rtc_pkg::MIN_LSB +: rtc_pkg::MIN_W];
                al_hour_q <= pwdata[rtc_pkg::HOUR_LSB +: rtc_pkg::HOUR_W];
            end
            if (wr_al_date) begin
                al_day_q <= pwdata[rtc_pkg::DAY_W-1:0];
            end
        end
    end

    // Compare one cycle after a tick, once the chain has settled; a
    // software write to time or alarm alone never fires the alarm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_moved_q <= 1'b0;
        end else begin
            time_moved_q <= sec_tick;
        end
    end

    // Whole time must match; it stays armed and hits again each 65536 days
    assign alarm_hit = time_moved_q && (sec_q == al_sec_q) && (min_q == al_min_q)
        && (hour_q == al_hour_q) && (day_q == al_day_q);

    // ==================================================================
    // Minute countdown
    logic [rtc_pkg::CNT_W-1:0] cnt_q;
    logic cnt_done;

    // Load is not aligned to the minute; first step is the next minute tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= rtc_pkg::CNT_RST;
        end else if (wr_cnt) begin
            cnt_q <= pwdata[rtc_pkg::CNT_W-1:0];
        end else if (min_tick && (cnt_q != rtc_pkg::CNT_EXPIRED)) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Flag on reaching minus one, and again each minute while it sits there
    assign cnt_done = min_tick && !wr_cnt
        && ((cnt_q == rtc_pkg::CNT_EXPIRED) || (cnt_q == '0));

    // ==================================================================
    // Status flags and enables
    logic [rtc_pkg::FLAG_W-1:0] flag_q;
    logic [rtc_pkg::FLAG_W-1:0] enable_q;
    logic [rtc_pkg::FLAG_W-1:0] flag_set;

    always_comb begin
        flag_set = '0;
        flag_set[rtc_pkg::BIT_COUNTDOWN] = cnt_done;
        flag_set[rtc_pkg::BIT_MINUTE] = min_tick;
        flag_set[rtc_pkg::BIT_ALARM] = alarm_hit;
        flag_set[rtc_pkg::BIT_MIDNIGHT] = day_tick;
        flag_set[rtc_pkg::BIT_SECOND] = sec_tick;
        flag_set[rtc_pkg::BIT_HOURLY] = hour_tick;
    end

    // Sticky flags, write one to clear; an event in the clear cycle wins.
    // Enables never gate the flags, only the request line.
    genvar gi;
    generate
        for (gi = 0; gi < rtc_pkg::FLAG_W; gi++) begin : g_flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_q[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flag_q[gi] <= 1'b1;
                end else if (wr_status && pstrb[0] && pwdata[gi]) begin
                    flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Enable register; clearing the alarm bit masks only the alarm request, the alarm flag still sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= rtc_pkg::ENABLE_RST;
        end else if (wr_enable && pstrb[0]) begin
            enable_q <= pwdata[rtc_pkg::FLAG_W-1:0];
        end
    end

    // Request line registered so the output comes straight from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_q & enable_q);
        end
    end

    // ==================================================================
    // Read data, ready and error
    logic [31:0] rd_mux;

    // Reserved bits read as zero
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            rtc_pkg::OFF_SS: rd_mux[rtc_pkg::SEC_W-1:0] = sec_q;
            rtc_pkg::OFF_HH_MM: begin
                rd_mux[rtc_pkg::MIN_LSB +: rtc_pkg::MIN_W] = min_q;
                rd_mux[rtc_pkg::HOUR_LSB +: rtc_pkg::HOUR_W] = hour_q;
            end
            rtc_pkg::OFF_STATUS: rd_mux[rtc_pkg::FLAG_W-1:0] = flag_q;
            rtc_pkg::OFF_ENABLE: rd_mux[rtc_pkg::FLAG_W-1:0] = enable_q;
            rtc_pkg::OFF_COUNTDOWN: rd_mux[rtc_pkg::CNT_W-1:0] = cnt_q;
            rtc_pkg::OFF_DAYS: rd_mux[rtc_pkg::DAY_W-1:0] = day_q;
            rtc_pkg::OFF_ALARM_SS: rd_mux[rtc_pkg::SEC_W-1:0] = al_sec_q;
            rtc_pkg::OFF_ALARM_HH_MM: begin
                rd_mux[rtc_pkg::MIN_LSB +: rtc_pkg::MIN_W] = al_min_q;
                rd_mux[rtc_pkg::HOUR_LSB +: rtc_pkg::HOUR_W] = al_hour_q;
            end
            rtc_pkg::OFF_ALARM_DATE: rd_mux[rtc_pkg::DAY_W-1:0] = al_day_q;
            default: rd_mux = '0;
        endcase
    end

    // Zero wait states: data captured at setup, ready in the access cycle.
    // A tick between the two edges is not reflected in that read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~addr_ok;
            if (setup_ph && !pwrite && addr_ok) begin
                prdata <= rd_mux;
            end else if (setup_ph) begin
                prdata <= '0;
            end
        end
    end

endmodule // rtc_day_counter

/* rtc_day_counter_chk.sv */
// Port-level assertions for the time-of-day counter block
`timescale 1ns/1ps

module rtc_day_counter_chk (
    input wire logic pclk,          // Bus clock
    input wire logic presetn,       // Reset, active low
    input wire logic psel,          // APB select
    input wire logic penable,       // APB access phase
    input wire logic pwrite,        // APB direction
    input wire logic [7:0] paddr,   // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb,   // APB strobes
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready,        // APB ready
    input wire logic pslverr,       // APB error
    input wire logic tick_1hz,      // Second tick
    input wire logic irq            // Interrupt request
);
    // ==========================================================
    // Helper logic
    logic tick_q;
    logic [3:0] quiet_q;
    logic en_wr;
    logic rd_acc;

    // Completed enable write, and a read in its access cycle
    assign en_wr = pready && penable && pwrite && paddr == rtc_pkg::OFF_ENABLE && pstrb[0];
    assign rd_acc = pready && !pwrite;

    // Cycles since a tick edge or enable write; saturates so it never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 1'b0;
            quiet_q <= 4'hF;
        end else begin
            tick_q <= tick_1hz;
            if ((tick_1hz && !tick_q) || en_wr) begin
                quiet_q <= 4'h0;
            end else if (quiet_q != 4'hF) begin
                quiet_q <= quiet_q + 4'h1;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    idle_ready_a: assert property (!psel |=> !pready && !pslverr)
        else $error("answer without select");
    mapped_ok_a: assert property (
        pready && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped register");
    day_upper_a: assert property (
        rd_acc && paddr == rtc_pkg::OFF_DAYS |-> prdata[31:16] == 16'h0000)
        else $error("day upper bits not zero");
    alarm_upper_a: assert property (
        rd_acc && paddr == rtc_pkg::OFF_ALARM_DATE |-> prdata[31:16] == 16'h0000)
        else $error("alarm day upper bits not zero");
    hh_mm_bits_a: assert property (
        rd_acc && paddr == rtc_pkg::OFF_HH_MM |-> prdata[31:13] == 19'h0 && prdata[7:6] == 2'b00)
        else $error("hour minute reserved bits set");
    sec_bits_a: assert property (rd_acc && paddr == rtc_pkg::OFF_SS |-> prdata[31:6] == 26'h0)
        else $error("seconds reserved bits set");
    irq_mask_a: assert property (en_wr && pwdata[5:0] == 6'h00 |=> ##1 !irq)
        else $error("irq with all enables clear");
    irq_cause_a: assert property ($rose(irq) |-> quiet_q <= 4'h8)
        else $error("irq rose without cause");
endmodule // rtc_day_counter_chk

bind rtc_day_counter rtc_day_counter_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_1hz(tick_1hz), .irq(irq));

/* tb_rtc.sv */
// Self-checking bench for the time-of-day counter block
`timescale 1ns/1ps

module tb;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tick_1hz;
    logic irq;
    integer bad_count;
    integer checked;
    integer seed;
    integer i;
    logic [31:0] v;
    logic [31:0] r;
    logic e;

    rtc_day_counter u_rtc_day_counter (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_1hz(tick_1hz), .irq(irq));

    // ==========================================================
    // Clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Expected hour-minute word
    function automatic logic [31:0] hm(input logic [4:0] h, input logic [5:0] m);
        return {19'h0, h, 2'b00, m};
    endfunction

    task automatic end_sim();
        $display("Counts: %0d checks, %0d mismatches", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; answer taken at the rising edge where pready is high,
    // then one idle edge so the next call never re-drives psel in that step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count = bad_count + 1;
            end_sim();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask

    // Tick with random high and low times, all above the synchroniser minimum
    task automatic tick();
        logic [31:0] t;
        t = $random(seed);
        tick_1hz <= 1'b1;
        repeat (4 + t[1:0]) @(posedge pclk);
        tick_1hz <= 1'b0;
        repeat (8 + t[3:2]) @(posedge pclk);
    endtask

    // irq is registered one edge after its cause, so one full cycle is let pass
    task automatic irq_is(input logic x);
        @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, x});
        @(posedge pclk);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count = bad_count + 1;
        end_sim();
    end

    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h3; // Low halfword lanes only
        tick_1hz = 1'b0;
        seed = 32'h2a5506a3;
        bad_count = 0;
        checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(rtc_pkg::OFF_ENABLE, 32'h0);
        rdc(rtc_pkg::OFF_STATUS, 32'h0);
        rdc(rtc_pkg::OFF_COUNTDOWN, 32'h3F);
        rdc(rtc_pkg::OFF_ALARM_HH_MM, 32'h0);
        rdc(rtc_pkg::OFF_ALARM_DATE, 32'h0);
        rdc(8'h24, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(8'h24, 32'h1);
        chk({31'h0, e}, 32'h1);
        $display("test reset values done");
        // Random values with all ones and all zeros as corners
        for (i = 0; i < 8; i = i + 1) begin
            v = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $random(seed);
            wr(rtc_pkg::OFF_DAYS, v);
            rdc(rtc_pkg::OFF_DAYS, {16'h0, v[15:0]});
            wr(rtc_pkg::OFF_ALARM_DATE, ~v);
            rdc(rtc_pkg::OFF_ALARM_DATE, {16'h0, ~v[15:0]});
            wr(rtc_pkg::OFF_HH_MM, hm(v[20:16] % 5'd24, v[29:24] % 6'd60));
            rdc(rtc_pkg::OFF_HH_MM, hm(v[20:16] % 5'd24, v[29:24] % 6'd60));
        end
        $display("test register access done");
        // Full rollover onto an alarm of all zeros, enables clear
        wr(rtc_pkg::OFF_SS, 32'h3B);
        wr(rtc_pkg::OFF_HH_MM, hm(5'h17, 6'h3B));
        wr(rtc_pkg::OFF_DAYS, 32'hFFFF);
        wr(rtc_pkg::OFF_ALARM_DATE, 32'h0);
        wr(rtc_pkg::OFF_COUNTDOWN, 32'h5);
        wr(rtc_pkg::OFF_STATUS, 32'h3F);
        tick();
        rdc(rtc_pkg::OFF_SS, 32'h0);
        rdc(rtc_pkg::OFF_HH_MM, 32'h0);
        rdc(rtc_pkg::OFF_DAYS, 32'h0);
        rdc(rtc_pkg::OFF_COUNTDOWN, 32'h4);
        rdc(rtc_pkg::OFF_STATUS, 32'h3E);
        irq_is(1'b0);
        tick();
        rdc(rtc_pkg::OFF_SS, 32'h1);
        rdc(rtc_pkg::OFF_HH_MM, 32'h0);
        $display("test rollover done");
        // Reset in mid-run keeps the day count
        wr(rtc_pkg::OFF_DAYS, 32'hBEEF);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(rtc_pkg::OFF_DAYS, 32'hBEEF);
        $display("test reset keeps day done");
        // Alarm fires, stays armed, then is disabled
        wr(rtc_pkg::OFF_HH_MM, hm(5'hA, 6'h14));
        wr(rtc_pkg::OFF_DAYS, 32'h5);
        wr(rtc_pkg::OFF_ALARM_SS, 32'h1E);
        wr(rtc_pkg::OFF_ALARM_HH_MM, hm(5'hA, 6'h14));
        wr(rtc_pkg::OFF_ALARM_DATE, 32'h5);
        wr(rtc_pkg::OFF_ENABLE, 32'h4);
        for (i = 0; i < 2; i = i + 1) begin
            wr(rtc_pkg::OFF_SS, 32'h1D);
            wr(rtc_pkg::OFF_STATUS, 32'h3F);
            tick();
            rdc(rtc_pkg::OFF_STATUS, 32'h14);
            irq_is(1'b1);
        end
        wr(rtc_pkg::OFF_ENABLE, 32'h0);
        irq_is(1'b0);
        rdc(rtc_pkg::OFF_STATUS, 32'h14);
        $display("test alarm done");
        // Countdown 1, 0, then held at minus one; enabled while held
        wr(rtc_pkg::OFF_COUNTDOWN, 32'h1);
        for (i = 0; i < 3; i = i + 1) begin
            wr(rtc_pkg::OFF_SS, 32'h3B);
            wr(rtc_pkg::OFF_STATUS, 32'h3F);
            wr(rtc_pkg::OFF_ENABLE, (i == 2) ? 32'h1 : 32'h0);
            tick();
            rdc(rtc_pkg::OFF_COUNTDOWN, (i == 0) ? 32'h0 : 32'h3F);
            rdc(rtc_pkg::OFF_STATUS, (i == 0) ? 32'h12 : 32'h13);
            irq_is(i == 2);
        end
        $display("test countdown done");
        end_sim();
    end
endmodule // tb
